// >>> hs_pkg.sv
// Constants, field layout and carrier types for the hot-swap and legacy decode block.
// Assumes a configuration access port with dword address and active-low byte enables.
// Behaviour
// - Capability ID byte reads constant 0x6
// - Next pointer read-only, resets zero
// - Software writes one to arm hiding
// - Arm set after reset with handle open
// - Arm cleared on entering insertion state
// - Mask bit gates enumeration output drive
// - Pending and interface fields read zero
// - LED bit lights indicator when one
// - Extraction flag set; write one clears
// - Insertion set after handle closed, reset
// - Either flag set asserts enumeration low
// - Legacy disabled: claim no legacy ranges
// - Enabled: claim game and FM ranges
// - Enabled: claim audio range
// - Enabled: claim MIDI range
package hs_pkg;

  localparam logic [7:0]  HS_CAP_OFS      = 8'h90;
  localparam logic [7:0]  MISC_CTRL_OFS   = 8'hC0;
  localparam logic [7:0]  HS_CAP_ID_VAL   = 8'h06;
  localparam logic [7:0]  HS_NEXT_RST     = 8'h00;
  localparam int          HIDE_ARM_BIT    = 16;
  localparam int          ENUM_MASK_BIT   = 17;
  localparam int          LED_BIT         = 19;
  localparam int          EXT_BIT         = 22;
  localparam int          INS_BIT         = 23;
  localparam int          LEGACY_EN_BIT   = 8;
  localparam logic [15:0] GAME_LO         = 16'h0200;
  localparam logic [15:0] GAME_HI         = 16'h0207;
  localparam logic [15:0] FM_LO           = 16'h0388;
  localparam logic [15:0] FM_HI           = 16'h038B;
  localparam logic [15:0] AUDIO_LO        = 16'h0220;
  localparam logic [15:0] AUDIO_HI        = 16'h0233;
  localparam logic [15:0] MIDI_LO         = 16'h0330;
  localparam logic [15:0] MIDI_HI         = 16'h0331;
  localparam logic [7:0]  CTRL_RST        = 8'h00;

  typedef enum logic [1:0] {
    SW_IDLE    = 2'b00,
    SW_INSERT  = 2'b01,
    SW_ACTIVE  = 2'b10,
    SW_EXTRACT = 2'b11
  } swap_state_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  primary_byte_enables_n;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    swap_state_t st;
    logic        hide_arm;
    logic        enum_out_mask;
    logic        led_control;
    logic        extraction_flag;
    logic        insertion_flag;
    logic        legacy_en;
    logic        handle_open;
    logic        rst_seen;
    logic        enum_n;
    logic        led;
    logic        claim;
    cfg_rsp_t    rsp;
  } hs_state_t;

endpackage

// >>> legacy_decode.sv
// Legacy ISA I/O range decoder for the secondary forwarding path.
// Assumes a 16-bit I/O address from the same clock domain.
`timescale 1ns/10ps
module legacy_decode (
  // Control
  input  wire logic        enable,
  // Address
  input  wire logic [15:0] io_addr,
  // Result
  output logic             hit
);
  import hs_pkg::*;

  logic game_hit;
  logic fm_hit;
  logic audio_hit;
  logic midi_hit;

  assign game_hit  = (io_addr >= GAME_LO) && (io_addr <= GAME_HI);
  assign fm_hit    = (io_addr >= FM_LO) && (io_addr <= FM_HI);
  assign audio_hit = (io_addr >= AUDIO_LO) && (io_addr <= AUDIO_HI);
  assign midi_hit  = (io_addr >= MIDI_LO) && (io_addr <= MIDI_HI);
  // Disabled decode claims nothing
  assign hit = enable && (game_hit || fm_hit || audio_hit || midi_hit);

endmodule

// >>> hot_swap_capability_regs.sv
// Hot-swap capability registers, enumeration and LED drive, legacy I/O claim.
// Assumes core_clk is the primary bus clock and arst_n the primary reset.
`timescale 1ns/10ps
module hot_swap_capability_regs (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  // Configuration access
  input  wire hs_pkg::cfg_req_t cfg_req,
  output hs_pkg::cfg_rsp_t      cfg_rsp,
  // Board ejector switch, high when handle open
  input  wire logic            handle_open_pin,
  // Primary I/O address decode
  input  wire logic            io_valid,
  input  wire logic [15:0]     io_addr,
  output logic                 io_claim,
  // Board signals
  output logic                 enum_n,
  output logic                 led_on
);
  import hs_pkg::*;

  hs_state_t s_r;
  hs_state_t s_nxt;
  logic [1:0] sw_sync_r;
  logic       dec_hit;
  logic [3:0] be;
  logic       hs_wr;
  logic       mc_wr;
  logic [31:0] hs_word;
  logic [31:0] mc_word;

  // Ejector switch synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_sync_r <= 2'h3;
    end else begin
      sw_sync_r <= {sw_sync_r[0], handle_open_pin};
    end
  end

  legacy_decode u_dec (
    .enable  (s_r.legacy_en),
    .io_addr (io_addr),
    .hit     (dec_hit)
  );

  assign be    = ~cfg_req.primary_byte_enables_n;
  assign hs_wr = cfg_req.wr && (cfg_req.addr == HS_CAP_OFS) && be[2];
  assign mc_wr = cfg_req.wr && (cfg_req.addr == MISC_CTRL_OFS) && be[1];

  always_comb begin
    hs_word = 32'h0;
    hs_word[7:0]  = HS_CAP_ID_VAL;
    hs_word[15:8] = HS_NEXT_RST;
    hs_word[HIDE_ARM_BIT]  = s_r.hide_arm;
    hs_word[ENUM_MASK_BIT] = s_r.enum_out_mask;
    hs_word[LED_BIT]       = s_r.led_control;
    hs_word[EXT_BIT]       = s_r.extraction_flag;
    hs_word[INS_BIT]       = s_r.insertion_flag;
    // Pending and interface bits stay zero
    mc_word = 32'h0;
    mc_word[LEGACY_EN_BIT] = s_r.legacy_en;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.handle_open = sw_sync_r[1];
    s_nxt.rst_seen    = 1'b1;
    // Register writes
    if (hs_wr) begin
      if (cfg_req.wdata[HIDE_ARM_BIT]) begin
        s_nxt.hide_arm = 1'b1;
      end
      s_nxt.enum_out_mask = cfg_req.wdata[ENUM_MASK_BIT];
      s_nxt.led_control   = cfg_req.wdata[LED_BIT];
    end
    if (hs_wr && be[2] && cfg_req.wdata[EXT_BIT]) begin
      s_nxt.extraction_flag = 1'b0;
    end
    if (hs_wr && cfg_req.wdata[INS_BIT]) begin
      s_nxt.insertion_flag = 1'b0;
    end
    if (mc_wr) begin
      s_nxt.legacy_en = cfg_req.wdata[LEGACY_EN_BIT];
    end
    // Hot-swap state machine; hardware sets win over software clears
    unique case (s_r.st)
      SW_IDLE: begin
        if (s_r.rst_seen && !s_r.handle_open) begin
          s_nxt.st = SW_INSERT;
          s_nxt.insertion_flag = 1'b1;
          s_nxt.hide_arm = 1'b0;
        end else if (s_r.rst_seen && s_r.handle_open) begin
          s_nxt.hide_arm = 1'b1;
        end
      end
      SW_INSERT: begin
        if (!s_r.insertion_flag) begin
          s_nxt.st = SW_ACTIVE;
        end
      end
      SW_ACTIVE: begin
        if (s_r.handle_open) begin
          s_nxt.st = SW_EXTRACT;
          s_nxt.extraction_flag = 1'b1;
          s_nxt.hide_arm = 1'b1;
        end
      end
      SW_EXTRACT: begin
        if (!s_r.extraction_flag && !s_r.handle_open) begin
          s_nxt.st = SW_IDLE;
        end
      end
    endcase
    // Board outputs
    s_nxt.enum_n = !((s_nxt.insertion_flag || s_nxt.extraction_flag)
                     && !s_nxt.enum_out_mask);
    s_nxt.led    = s_nxt.led_control;
    s_nxt.claim  = io_valid && dec_hit;
    // Read answer
    s_nxt.rsp.valid = cfg_req.rd;
    if (cfg_req.rd && cfg_req.addr == HS_CAP_OFS) begin
      s_nxt.rsp.rdata = hs_word;
    end else if (cfg_req.rd && cfg_req.addr == MISC_CTRL_OFS) begin
      s_nxt.rsp.rdata = mc_word;
    end else begin
      s_nxt.rsp.rdata = 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{st: SW_IDLE, hide_arm: 1'b0, enum_out_mask: 1'b0, led_control: 1'b0,
               extraction_flag: 1'b0, insertion_flag: 1'b0, legacy_en: 1'b0,
               handle_open: 1'b1, rst_seen: 1'b0, enum_n: 1'b1, led: 1'b0,
               claim: 1'b0, rsp: '{valid: 1'b0, rdata: 32'h0}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg_rsp  = s_r.rsp;
  assign io_claim = s_r.claim;
  assign enum_n   = s_r.enum_n;
  assign led_on   = s_r.led;

  // Assertions
  property p_enum;
    @(posedge core_clk) disable iff (!arst_n)
      ((s_r.insertion_flag || s_r.extraction_flag) && !s_r.enum_out_mask) |-> !enum_n;
  endproperty
  enum_drive_a: assert property (p_enum) else $error("enum not driven");
  enum_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_r.enum_out_mask |-> enum_n) else $error("masked enum driven");
  cap_id_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cfg_req.rd && cfg_req.addr == HS_CAP_OFS) |=> cfg_rsp.rdata[15:0] == 16'h0006)
    else $error("cap id or next wrong");
  ro_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cfg_req.rd && cfg_req.addr == HS_CAP_OFS) |=> cfg_rsp.rdata[21:20] == 2'h0
    && !cfg_rsp.rdata[18]) else $error("ro bits nonzero");
  led_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    hs_wr |=> led_on == $past(cfg_req.wdata[LED_BIT]))
    else $error("led mismatch");
  claim_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !s_r.legacy_en |=> !io_claim) else $error("claim while disabled");
  game_claim_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.legacy_en && io_valid && io_addr == 16'h0204) |=> io_claim)
    else $error("game port not claimed");
  ins_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.st == SW_IDLE && s_r.rst_seen && !s_r.handle_open) |=> s_r.insertion_flag
    && !s_r.hide_arm) else $error("insertion not set");
  zero_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.insertion_flag && hs_wr && !cfg_req.wdata[INS_BIT]) |=> s_r.insertion_flag)
    else $error("flag lost on zero write");

  // Steps of the extraction event
  sequence s_ext_cause;
    s_r.st == SW_ACTIVE && s_r.handle_open;
  endsequence
  sequence s_ext_seen;
    s_r.extraction_flag && s_r.hide_arm && s_r.st == SW_EXTRACT;
  endsequence
  property p_ext_set;
    @(posedge core_clk) disable iff (!arst_n)
      s_ext_cause |=> s_ext_seen;
  endproperty
  ext_set_a: assert property (p_ext_set) else $error("extraction not set");

  // Steps of the idle arming
  sequence s_idle_open;
    s_r.st == SW_IDLE && s_r.rst_seen && s_r.handle_open;
  endsequence
  property p_hide_idle;
    @(posedge core_clk) disable iff (!arst_n)
      s_idle_open |=> s_r.hide_arm;
  endproperty
  hide_idle_a: assert property (p_hide_idle) else $error("hide arm not set");

  hide_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (hs_wr && cfg_req.wdata[HIDE_ARM_BIT] && s_r.st != SW_IDLE) |=> s_r.hide_arm)
    else $error("hide arm write lost");
  mask_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    hs_wr |=> s_r.enum_out_mask == $past(cfg_req.wdata[ENUM_MASK_BIT]))
    else $error("mask write lost");
  ins_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.st == SW_INSERT && hs_wr && cfg_req.wdata[INS_BIT]) |=> !s_r.insertion_flag)
    else $error("insertion not cleared");
  misc_rsv_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cfg_req.rd && cfg_req.addr == MISC_CTRL_OFS) |=> cfg_rsp.rdata[15:9] == 7'h00)
    else $error("reserved bits nonzero");
  fm_claim_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.legacy_en && io_valid && io_addr == 16'h038B) |=> io_claim)
    else $error("fm range not claimed");
  audio_claim_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.legacy_en && io_valid && io_addr == 16'h0233) |=> io_claim)
    else $error("audio range not claimed");
  midi_claim_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_r.legacy_en && io_valid && io_addr == 16'h0330) |=> io_claim)
    else $error("midi range not claimed");

endmodule

// >>> ejector_switch_model.sv
// Ejector switch model: handle position seen as a contact level.
// Assumes the bench moves the handle just after a rising clock edge.
`timescale 1ns/10ps
module ejector_switch_model (
  // Clock
  input  wire logic core_clk,
  // Handle command, high to open
  input  wire logic open_cmd,
  // Contact, high when open
  output logic      handle_open_pin
);
  initial handle_open_pin = 1'b1;
  always @(posedge core_clk) begin
    handle_open_pin <= open_cmd;
  end
endmodule

// >>> hot_swap_capability_regs_bench.sv
// Self-checking bench for the hot-swap registers and legacy decode.
// Assumes hs_pkg and the ejector switch model are compiled first.
`timescale 1ns/10ps
module hot_swap_capability_regs_bench;
  import hs_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic        open_cmd = 1'b1;
  logic        io_valid = 1'b0;
  logic [15:0] io_addr  = 16'h0000;
  logic        handle_open_pin, enum_n, led_on, io_claim;
  logic [31:0] rd_v;
  cfg_req_t    cfg_req  = '0;
  cfg_rsp_t    cfg_rsp;
  int          checked = 0, miscompares = 0, cycles = 0;
  logic [15:0] addrs [16] = '{16'h0200, 16'h0207, 16'h0388, 16'h038B, 16'h0220, 16'h0233,
    16'h0330, 16'h0331, 16'h01FF, 16'h0208, 16'h0387, 16'h038C, 16'h021F, 16'h0234,
    16'h032F, 16'h0332};

  always #2.5 core_clk = ~core_clk;

  ejector_switch_model switch_u (.core_clk(core_clk), .open_cmd(open_cmd),
    .handle_open_pin(handle_open_pin));
  hot_swap_capability_regs dut_u (.core_clk(core_clk), .arst_n(arst_n), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .handle_open_pin(handle_open_pin), .io_valid(io_valid),
    .io_addr(io_addr), .io_claim(io_claim), .enum_n(enum_n), .led_on(led_on));

  task automatic results();
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] ben,
                     input logic [31:0] wd);
    @(posedge core_clk);
    cfg_req <= '{rd: ~wr, wr: wr, addr: a, primary_byte_enables_n: ben, wdata: wd};
    @(posedge core_clk);
    cfg_req <= '0;
    #1 rd_v = cfg_rsp.valid ? cfg_rsp.rdata : 32'hXXXXXXXX;
  endtask

  task automatic wait_enum(input logic lvl);
    for (int i = 0; i < 20 && enum_n !== lvl; i++) @(posedge core_clk);
    #1;
  endtask

  task automatic probe(input logic [15:0] a, input logic exp);
    @(posedge core_clk);
    io_valid <= 1'b1;
    io_addr  <= a;
    @(posedge core_clk);
    io_valid <= 1'b0;
    #1 chk("io_claim", {31'h0, io_claim}, {31'h0, exp});
  endtask

  task automatic t_reset();
    repeat (4) @(posedge core_clk);
    cfg(1'b0, HS_CAP_OFS, 4'h0, 32'h0);
    chk("hs_word", rd_v, 32'h00010006);
    chk("enum_n", {31'h0, enum_n}, 32'h1);
  endtask

  task automatic t_write();
    cfg(1'b1, HS_CAP_OFS, 4'hB, 32'h003F0000);
    cfg(1'b1, HS_CAP_OFS, 4'hF, 32'h00000000);
    cfg(1'b0, HS_CAP_OFS, 4'h0, 32'h0);
    chk("hs_word", rd_v, 32'h000B0006);
    chk("led_on", {31'h0, led_on}, 32'h1);
    cfg(1'b1, HS_CAP_OFS, 4'hB, 32'h00010000);
    @(posedge core_clk);
    #1 chk("led_on", {31'h0, led_on}, 32'h0);
  endtask

  task automatic t_insert();
    @(posedge core_clk);
    open_cmd <= 1'b0;
    wait_enum(1'b0);
    chk("enum_n", {31'h0, enum_n}, 32'h0);
    cfg(1'b1, HS_CAP_OFS, 4'hB, 32'h00000000);
    cfg(1'b0, HS_CAP_OFS, 4'h0, 32'h0);
    chk("hs_word", rd_v, 32'h00800006);
    cfg(1'b1, HS_CAP_OFS, 4'hB, 32'h00020000);
    @(posedge core_clk);
    #1 chk("enum_n", {31'h0, enum_n}, 32'h1);
    cfg(1'b1, HS_CAP_OFS, 4'hB, 32'h00800000);
    cfg(1'b0, HS_CAP_OFS, 4'h0, 32'h0);
    chk("hs_word", rd_v, 32'h00000006);
    chk("enum_n", {31'h0, enum_n}, 32'h1);
    cfg(1'b1, HS_CAP_OFS, 4'hB, 32'h00010000);
    cfg(1'b0, HS_CAP_OFS, 4'h0, 32'h0);
    chk("hs_word", rd_v, 32'h00010006);
  endtask

  task automatic t_extract();
    @(posedge core_clk);
    open_cmd <= 1'b1;
    wait_enum(1'b0);
    cfg(1'b0, HS_CAP_OFS, 4'h0, 32'h0);
    chk("ext_flag", rd_v & 32'h00400000, 32'h00400000);
    cfg(1'b1, HS_CAP_OFS, 4'hB, 32'h00400000);
    wait_enum(1'b1);
    cfg(1'b0, HS_CAP_OFS, 4'h0, 32'h0);
    chk("ext_flag", rd_v & 32'h00400000, 32'h0);
    chk("enum_n", {31'h0, enum_n}, 32'h1);
  endtask

  task automatic t_legacy();
    for (int i = 0; i < 8; i++) probe(addrs[i], 1'b0);
    cfg(1'b1, MISC_CTRL_OFS, 4'hD, 32'h0000FFFF);
    cfg(1'b0, MISC_CTRL_OFS, 4'h0, 32'h0);
    chk("misc_ctrl", rd_v, 32'h00000100);
    for (int i = 0; i < 16; i++) probe(addrs[i], i < 8);
    cfg(1'b0, 8'h44, 4'h0, 32'h0);
    chk("unmapped", rd_v, 32'h0);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_write();
    t_insert();
    t_extract();
    t_legacy();
    results();
  end
endmodule
